// [hdl/clk_mgr_pkg.sv]
/*
  Constants and types shared by the dual-domain clock manager.
  Assumes a 32-bit APB bus with byte addresses and word registers.
*/
package clk_mgr_pkg;

  // ----------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------
  localparam logic [7:0] OFS_CTRL1 = 8'h00;
  localparam logic [7:0] OFS_CTRL2 = 8'h04;
  localparam logic [7:0] OFS_TRIM  = 8'h08;
  localparam logic [7:0] OFS_PRESC = 8'h0C;
  localparam logic [7:0] OFS_STAT  = 8'h10;

  // ----------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------
  localparam int C1_RANGE = 0;
  localparam int C1_RCEN  = 1;
  localparam int C1_CS    = 2;
  localparam int C1_RDY   = 4;
  localparam int C1_LVL   = 5;
  localparam int C2_DIV   = 0;
  localparam int C2_XEN   = 2;
  localparam int C2_CPULO = 3;
  localparam int C2_EXTH  = 4;
  localparam int C2_PIN   = 5;
  localparam int C2_EXTL  = 6;
  localparam int PR_P1    = 0;
  localparam int PR_P2    = 3;
  localparam int ST_RC    = 0;
  localparam int ST_XTAL  = 1;
  localparam int ST_CPULO = 2;
  localparam int ST_HIEXT = 3;

  // ----------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------
  localparam logic [1:0] DIV_RST  = 2'h3;
  localparam logic [7:0] TRIM_RST = 8'h7F;
  localparam logic [2:0] P1_RST   = 3'h1;
  localparam logic [2:0] P1_LOW   = 3'h0;

  // ----------------------------------------------------------
  // Cold-start lengths in crystal periods
  // ----------------------------------------------------------
  localparam logic [15:0] CS_LEN_00 = 16'h8000;
  localparam logic [15:0] CS_LEN_10 = 16'h6000;
  localparam logic [15:0] CS_LEN_01 = 16'h4000;
  localparam logic [15:0] CS_LEN_11 = 16'h2000;

  // ----------------------------------------------------------
  // Configuration carrier
  // ----------------------------------------------------------
  typedef struct packed {
    logic       rc_range_select;
    logic       rc_osc_enable;
    logic [1:0] cold_start_length_code;
    logic [1:0] rc_predivider_code;
    logic       crystal_enable;
    logic       cpu_low_clock_select;
    logic       ext_high_clock_select;
    logic       ext_high_pin_choice;
    logic       ext_low_clock_select;
    logic [7:0] rc_trim;
    logic [2:0] prescaler_one_input_code;
    logic       prescaler_two_input_select;
  } cfg_type;

  localparam cfg_type CFG_RST = '{
    rc_range_select:            1'b0,
    rc_osc_enable:              1'b1,
    cold_start_length_code:     2'h0,
    rc_predivider_code:         DIV_RST,
    crystal_enable:             1'b0,
    cpu_low_clock_select:       1'b0,
    ext_high_clock_select:      1'b0,
    ext_high_pin_choice:        1'b0,
    ext_low_clock_select:       1'b0,
    rc_trim:                    TRIM_RST,
    prescaler_one_input_code:   P1_RST,
    prescaler_two_input_select: 1'b1
  };

endpackage

// [hdl/dual_domain_clock_manager.sv]
/*
  Dual-domain clock manager: RC control and pre-divider, external high
  clock pins, crystal cold start, external low clock, glitch-free
  switches and an APB register file.
  Assumes all clock sources are slow against ref_clk and are sampled;
  the CPU halt level comes from logic on ref_clk.
*/
// The APB interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps

module clk_glitch_switch (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic reset,
  // Selection and sampled sources
  input  wire logic sel,
  input  wire logic clk_a,
  input  wire logic clk_b,
  // Gated clock and current source
  output logic      out_q,
  output logic      cur_q
);

  logic en_q;
  logic old_clk;
  logic new_clk;

  assign old_clk = cur_q ? clk_b : clk_a;
  assign new_clk = sel ? clk_b : clk_a;

  // Gate off while the old source is low, then hand over on a new falling edge.
  logic new_prev_q;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      en_q       <= 1'b1;
      cur_q      <= 1'b0;
      new_prev_q <= 1'b0;
    end else begin
      new_prev_q <= new_clk;
      if (en_q && sel != cur_q && !old_clk) begin
        en_q <= 1'b0;
      end else if (!en_q && new_prev_q && !new_clk) begin
        en_q  <= 1'b1;
        cur_q <= sel;
      end
    end
  end

  // Output flop carries the gated clock.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      out_q <= 1'b0;
    end else begin
      out_q <= en_q & old_clk;
    end
  end

  default clocking sw_cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_leave;
    en_q && sel != cur_q && !old_clk;
  endsequence

  AST_SW_FORCE: assert property (s_leave |=> !en_q ##1 !out_q)
    else $error("Switch did not force its output low.");

endmodule // clk_glitch_switch

module dual_domain_clock_manager
  import clk_mgr_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        reset,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Clock sources and pins
  input  wire logic        rc_osc_clock,
  input  wire logic        port_pin4,
  input  wire logic        port_pin5,
  input  wire logic        crystal_clock,
  input  wire logic        osc_output_terminal,
  input  wire logic        cpu_halted,
  // Oscillator controls
  output logic             rc_osc_run,
  output logic             rc_range_select,
  output logic [7:0]       rc_trim,
  output logic             crystal_run,
  output logic             ext_low_input_enable,
  // Generated clocks
  output logic             high_domain_clock,
  output logic             low_domain_clock,
  output logic             cpu_clock
);

  // ----------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------
  localparam int NS = 5;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;
  logic [NS-1:0] s3_q;
  logic [NS-1:0] raw;

  assign raw = {osc_output_terminal, crystal_clock, port_pin5, port_pin4, rc_osc_clock};

  // Two stages, plus a third copy for edge detection.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ----------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------
  cfg_type     cfg_q;
  logic        rdy_q;
  logic        done_q;
  logic [15:0] cs_cnt_q;
  logic        cpu_cur_low;
  logic        hi_cur_ext;
  logic        ext_lf_act;
  logic        term_level;

  logic        acc;
  logic        wr;
  logic        hit;
  logic [31:0] rd;

  assign acc = psel & penable;
  assign wr  = acc & pready & pwrite;

  // Software writes; reset gives RC 1 MHz, divide by 8, trim 7F.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cfg_q <= CFG_RST;
    end else if (wr) begin
      case (paddr)
        OFS_CTRL1: begin
          cfg_q.rc_range_select        <= pwdata[C1_RANGE];
          cfg_q.rc_osc_enable          <= pwdata[C1_RCEN];
          cfg_q.cold_start_length_code <= pwdata[C1_CS+:2];
        end
        OFS_CTRL2: begin
          cfg_q.rc_predivider_code    <= pwdata[C2_DIV+:2];
          cfg_q.crystal_enable        <= pwdata[C2_XEN];
          cfg_q.cpu_low_clock_select  <= pwdata[C2_CPULO];
          cfg_q.ext_high_clock_select <= pwdata[C2_EXTH];
          cfg_q.ext_high_pin_choice   <= pwdata[C2_PIN];
          cfg_q.ext_low_clock_select  <= pwdata[C2_EXTL];
        end
        OFS_TRIM: begin
          cfg_q.rc_trim <= pwdata[7:0];
        end
        OFS_PRESC: begin
          cfg_q.prescaler_one_input_code   <= pwdata[PR_P1+:3];
          cfg_q.prescaler_two_input_select <= pwdata[PR_P2];
        end
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------------------------
  // APB read path
  // ----------------------------------------------------------
  // Read mux and address decode.
  always_comb begin
    rd  = '0;
    hit = 1'b1;
    case (paddr)
      OFS_CTRL1: begin
        rd[C1_RANGE]  = cfg_q.rc_range_select;
        rd[C1_RCEN]   = cfg_q.rc_osc_enable;
        rd[C1_CS+:2]  = cfg_q.cold_start_length_code;
        rd[C1_RDY]    = rdy_q;
        rd[C1_LVL]    = term_level;
      end
      OFS_CTRL2: begin
        rd[C2_DIV+:2] = cfg_q.rc_predivider_code;
        rd[C2_XEN]    = cfg_q.crystal_enable;
        rd[C2_CPULO]  = cfg_q.cpu_low_clock_select;
        rd[C2_EXTH]   = cfg_q.ext_high_clock_select;
        rd[C2_PIN]    = cfg_q.ext_high_pin_choice;
        rd[C2_EXTL]   = cfg_q.ext_low_clock_select;
      end
      OFS_TRIM: begin
        rd[7:0] = cfg_q.rc_trim;
      end
      OFS_PRESC: begin
        rd[PR_P1+:3] = cfg_q.prescaler_one_input_code;
        rd[PR_P2]    = cfg_q.prescaler_two_input_select;
      end
      OFS_STAT: begin
        rd[ST_RC]    = rc_osc_run;
        rd[ST_XTAL]  = crystal_run;
        rd[ST_CPULO] = cpu_cur_low;
        rd[ST_HIEXT] = hi_cur_ext;
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end

  // One wait state: pready rises in the second access cycle.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc & ~pready;
      prdata  <= (acc & ~pready) ? rd : '0;
      pslverr <= acc & ~pready & ~hit;
    end
  end

  // ----------------------------------------------------------
  // RC oscillator control
  // ----------------------------------------------------------
  logic presc_rc;
  logic rc_cpu;
  logic rc_run_d;

  // Prescaler 2 on the high input is the only prescaler path to the RC.
  assign presc_rc = ~cfg_q.ext_high_clock_select & cfg_q.prescaler_two_input_select;
  assign rc_cpu   = ~cfg_q.ext_high_clock_select & ~cpu_cur_low;
  assign rc_run_d = presc_rc | (~cpu_halted & (cfg_q.rc_osc_enable | rc_cpu));

  // Oscillator run, range and trim drive the analogue cell.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rc_osc_run      <= 1'b1;
      rc_range_select <= 1'b0;
      rc_trim         <= TRIM_RST;
    end else begin
      rc_osc_run      <= rc_run_d;
      rc_range_select <= cfg_q.rc_range_select;
      rc_trim         <= cfg_q.rc_trim;
    end
  end

  // ----------------------------------------------------------
  // Pre-divider and high domain
  // ----------------------------------------------------------
  logic [2:0] pdiv_q;
  logic       rc_div;
  logic       hf_ext;

  // Counts rising edges of the sampled RC clock.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pdiv_q <= '0;
    end else if (s2_q[0] && !s3_q[0]) begin
      pdiv_q <= pdiv_q + 3'h1;
    end
  end

  // Divider code picks pass, /2, /4 or /8.
  always_comb begin
    case (cfg_q.rc_predivider_code)
      2'h0:    rc_div = s2_q[0];
      2'h1:    rc_div = pdiv_q[0];
      2'h2:    rc_div = pdiv_q[1];
      default: rc_div = pdiv_q[2];
    endcase
  end

  assign hf_ext = cfg_q.ext_high_pin_choice ? s2_q[2] : s2_q[1];

  clk_glitch_switch u_hi_sw (
    .ref_clk (ref_clk),
    .reset   (reset),
    .sel     (cfg_q.ext_high_clock_select),
    .clk_a   (rc_div),
    .clk_b   (hf_ext),
    .out_q   (high_domain_clock),
    .cur_q   (hi_cur_ext)
  );

  // ----------------------------------------------------------
  // Crystal and cold start
  // ----------------------------------------------------------
  logic        lf_demand;
  logic        xtal_run_d;
  logic        xtal_rise;
  logic [15:0] cs_lim;

  assign ext_lf_act = cfg_q.ext_low_clock_select & ~cfg_q.crystal_enable;
  assign lf_demand  = cfg_q.cpu_low_clock_select | (cfg_q.prescaler_one_input_code == P1_LOW)
                    | ~cfg_q.prescaler_two_input_select;
  assign xtal_run_d = cfg_q.crystal_enable | (~cfg_q.ext_low_clock_select & lf_demand);
  assign xtal_rise  = crystal_run & s2_q[3] & ~s3_q[3];
  assign term_level = ~cfg_q.crystal_enable & s2_q[4];

  // Cold-start length table.
  always_comb begin
    case (cfg_q.cold_start_length_code)
      2'h0:    cs_lim = CS_LEN_00;
      2'h2:    cs_lim = CS_LEN_10;
      2'h1:    cs_lim = CS_LEN_01;
      default: cs_lim = CS_LEN_11;
    endcase
  end

  // Crystal run and input block outputs.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      crystal_run          <= 1'b0;
      ext_low_input_enable <= 1'b0;
    end else begin
      crystal_run          <= xtal_run_d;
      ext_low_input_enable <= ~cfg_q.crystal_enable;
    end
  end

  // Counts crystal periods; a stopped crystal clears the count.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      cs_cnt_q <= '0;
      done_q   <= 1'b0;
    end else if (!crystal_run) begin
      cs_cnt_q <= '0;
      done_q   <= 1'b0;
    end else if (!done_q && xtal_rise) begin
      if (cs_cnt_q == cs_lim - 16'h1) begin
        done_q <= 1'b1;
      end else begin
        cs_cnt_q <= cs_cnt_q + 16'h1;
      end
    end
  end

  // Ready flag, forced while the external low clock is in use.
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      rdy_q <= 1'b0;
    end else begin
      rdy_q <= ext_lf_act | done_q;
    end
  end

  // ----------------------------------------------------------
  // Low domain and CPU clock
  // ----------------------------------------------------------
  logic xtal_src;
  assign xtal_src = crystal_run & s2_q[3];

  // Crystal feeds the low domain during cold start as well.
  clk_glitch_switch u_lo_sw (
    .ref_clk (ref_clk),
    .reset   (reset),
    .sel     (ext_lf_act),
    .clk_a   (xtal_src),
    .clk_b   (s2_q[4]),
    .out_q   (low_domain_clock),
    .cur_q   ()
  );

  // CPU takes the low domain only once the ready flag is set.
  clk_glitch_switch u_cpu_sw (
    .ref_clk (ref_clk),
    .reset   (reset),
    .sel     (cfg_q.cpu_low_clock_select & rdy_q),
    .clk_a   (high_domain_clock),
    .clk_b   (low_domain_clock),
    .out_q   (cpu_clock),
    .cur_q   (cpu_cur_low)
  );

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence s_cs_last;
    crystal_run && !done_q && xtal_rise && cs_cnt_q == cs_lim - 16'h1;
  endsequence

  AST_RST_RC: assert property ($fell(reset) |-> rc_osc_run && cfg_q.rc_predivider_code == 2'h3)
    else $error("RC not at reset setting.");
  AST_DIV1: assert property (cfg_q.rc_predivider_code == 2'h0 |-> rc_div == s2_q[0])
    else $error("Divide by one wrong.");
  AST_RANGE: assert property ($changed(cfg_q.rc_range_select) |=> rc_range_select == $past(cfg_q.rc_range_select))
    else $error("Range output lags.");
  AST_TRIM_RST: assert property ($fell(reset) |-> rc_trim == 8'h7F)
    else $error("Trim reset wrong.");
  AST_RC_ON: assert property (cfg_q.rc_osc_enable && !cpu_halted |=> rc_osc_run)
    else $error("RC not started.");
  AST_HALT: assert property (cpu_halted && !presc_rc |=> !rc_osc_run)
    else $error("RC kept on in halt.");
  AST_XTAL_RST: assert property ($fell(reset) |-> !crystal_run && !rdy_q)
    else $error("Crystal on after reset.");
  AST_CS_END: assert property (s_cs_last |=> done_q ##1 rdy_q)
    else $error("Cold start end missed.");
  AST_RESTART: assert property (!crystal_run |=> cs_cnt_q == 16'h0 && !done_q)
    else $error("Cold start not restarted.");
  AST_IMPLICIT: assert property (!cfg_q.ext_low_clock_select && lf_demand |=> crystal_run)
    else $error("Crystal not started by demand.");
  AST_EXT_RDY: assert property (ext_lf_act [*2] |-> rdy_q)
    else $error("Ready not forced.");
  AST_BLOCK: assert property (cfg_q.crystal_enable |=> !ext_low_input_enable)
    else $error("External low input not blocked.");

endmodule // dual_domain_clock_manager

// [bench/clock_source_model.sv]
/*
  Model of the clock sources around the clock manager.
  Assumes ref_clk at 200 MHz; every source is slow against it.
*/
`timescale 1ns/1ps

module clock_source_model (
  // Clock
  input  wire logic ref_clk,
  // Controls from the manager and the bench
  input  wire logic rc_osc_run,
  input  wire logic crystal_run,
  input  wire logic ext_low_on,
  input  wire logic ext_low_level,
  input  wire logic pin_on,
  // Source outputs
  output logic      rc_osc_clock,
  output logic      port_pin4,
  output logic      port_pin5,
  output logic      crystal_clock,
  output logic      osc_output_terminal
);
  // ----------------------------------------
  // Source generation
  // ----------------------------------------
  logic [9:0] cnt_q = 10'h000;

  // Free counter that paces every source.
  always_ff @(posedge ref_clk) begin
    cnt_q <= cnt_q + 10'h001;
  end

  // Stopped oscillators rest low instead of holding a stale phase.
  assign rc_osc_clock  = rc_osc_run & cnt_q[2];
  assign crystal_clock = crystal_run & cnt_q[1];
  assign port_pin4     = pin_on & cnt_q[3];
  assign port_pin5     = pin_on & cnt_q[2];
  // The external low clock is kept below an eighth of the high clock.
  assign osc_output_terminal = crystal_run ? cnt_q[1] :
                               (ext_low_on ? cnt_q[9] : ext_low_level);
endmodule // clock_source_model

// [bench/dual_domain_clock_manager_tb.sv]
/*
  Self-checking bench for the dual-domain clock manager.
  Assumes clk_mgr_pkg and the clock source model are compiled first.
*/
`timescale 1ns/1ps

module dual_domain_clock_manager_tb import clk_mgr_pkg::*; ;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic        ref_clk       = 1'b0;
  logic        reset         = 1'b1;
  logic        psel          = 1'b0;
  logic        penable       = 1'b0;
  logic        pwrite        = 1'b0;
  logic [7:0]  paddr         = 8'h00;
  logic [31:0] pwdata        = 32'h0;
  logic        cpu_halted    = 1'b0;
  logic        ext_low_on    = 1'b0;
  logic        ext_low_level = 1'b0;
  logic        pin_on        = 1'b0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err;
  logic        rc_osc_clock, port_pin4, port_pin5, crystal_clock, osc_output_terminal;
  logic        rc_osc_run, rc_range_select, crystal_run, ext_low_input_enable;
  logic        high_domain_clock, low_domain_clock, cpu_clock;
  logic [7:0]  rc_trim;
  int          errors        = 0;
  int          n_tests       = 0;
  int          n;

  // Clock of 5 ns period.
  always #2.5 ref_clk = ~ref_clk;

  dual_domain_clock_manager dut (.ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rc_osc_clock(rc_osc_clock), .port_pin4(port_pin4), .port_pin5(port_pin5),
    .crystal_clock(crystal_clock), .osc_output_terminal(osc_output_terminal),
    .cpu_halted(cpu_halted), .rc_osc_run(rc_osc_run), .rc_range_select(rc_range_select),
    .rc_trim(rc_trim), .crystal_run(crystal_run), .ext_low_input_enable(ext_low_input_enable),
    .high_domain_clock(high_domain_clock), .low_domain_clock(low_domain_clock),
    .cpu_clock(cpu_clock));

  clock_source_model src (.ref_clk(ref_clk), .rc_osc_run(rc_osc_run), .crystal_run(crystal_run),
    .ext_low_on(ext_low_on), .ext_low_level(ext_low_level), .pin_on(pin_on),
    .rc_osc_clock(rc_osc_clock), .port_pin4(port_pin4), .port_pin5(port_pin5),
    .crystal_clock(crystal_clock), .osc_output_terminal(osc_output_terminal));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Ends the run with the verdict.
  task automatic summarize();
    if (errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Compares one value and reports a difference.
  task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // One APB transfer; the request holds until pready is sampled high.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge ref_clk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1) begin
      errors++;
      summarize();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  // Register read compared with a whole word.
  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask

  // Lets synchronisers settle, then counts rising edges of one clock.
  task automatic count(input logic lo, input int cyc, output int c);
    logic p;
    c = 0;
    repeat (32) @(posedge ref_clk);
    p = lo ? low_domain_clock : high_domain_clock;
    repeat (cyc) begin
      @(posedge ref_clk);
      if ((lo ? low_domain_clock : high_domain_clock) === 1'b1 && p === 1'b0) c++;
      p = lo ? low_domain_clock : high_domain_clock;
    end
  endtask

  // Edge count within one of the expected figure.
  task automatic near(input string name, input int c, input int e);
    check(name, {31'h0, (c >= e - 1) && (c <= e + 1)}, 32'h1);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Reset values, unmapped address.
  task automatic t_reset();
    rdchk("ctrl1", OFS_CTRL1, 32'h2);
    rdchk("ctrl2", OFS_CTRL2, 32'h3);
    rdchk("trim", OFS_TRIM, 32'h7F);
    rdchk("presc", OFS_PRESC, 32'h9);
    rdchk("status", OFS_STAT, 32'h1);
    check("rc_run", {31'h0, rc_osc_run}, 32'h1);
    check("xtal_run", {31'h0, crystal_run}, 32'h0);
    rdchk("unmapped", 8'h14, 32'h0);
    check("slverr", {31'h0, err}, 32'h1);
  endtask

  // Range, trim and divider.
  task automatic t_rc();
    wr(OFS_CTRL1, 32'h13);
    wr(OFS_TRIM, 32'hFF);
    rdchk("ctrl1_ro", OFS_CTRL1, 32'h3);
    check("range1", {31'h0, rc_range_select}, 32'h1);
    check("trim_ff", {24'h0, rc_trim}, 32'hFF);
    wr(OFS_CTRL1, 32'h2);
    wr(OFS_TRIM, 32'h0);
    // The oscillator controls follow the register one cycle after the write edge.
    repeat (2) @(posedge ref_clk);
    check("range0", {31'h0, rc_range_select}, 32'h0);
    check("trim_00", {24'h0, rc_trim}, 32'h0);
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CTRL2, c);
      count(1'b0, 512, n);
      near("div", n, 512 / (8 << c));
    end
  endtask

  // External high clock from either pin.
  task automatic t_ext_high();
    pin_on <= 1'b1;
    wr(OFS_CTRL2, 32'h10);
    count(1'b0, 512, n);
    near("pin4", n, 32);
    rdchk("st_ext", OFS_STAT, 32'h9);
    wr(OFS_CTRL2, 32'h30);
    count(1'b0, 512, n);
    near("pin5", n, 64);
    wr(OFS_CTRL2, 32'h3);
    pin_on <= 1'b0;
  endtask

  // RC stop under halt, and RC kept running with the enable bit clear while in use.
  task automatic t_halt();
    cpu_halted <= 1'b1;
    repeat (20) @(posedge ref_clk);
    check("halt_kept", {31'h0, rc_osc_run}, 32'h1);
    wr(OFS_PRESC, 32'h1);
    repeat (20) @(posedge ref_clk);
    check("halt_off", {31'h0, rc_osc_run}, 32'h0);
    check("implicit", {31'h0, crystal_run}, 32'h1);
    cpu_halted <= 1'b0;
    repeat (20) @(posedge ref_clk);
    check("halt_end", {31'h0, rc_osc_run}, 32'h1);
    wr(OFS_PRESC, 32'h9);
    wr(OFS_CTRL1, 32'h0);
    repeat (20) @(posedge ref_clk);
    check("rc_in_use", {31'h0, rc_osc_run}, 32'h1);
    wr(OFS_CTRL1, 32'h2);
  endtask

  // Crystal cold start, CPU move, RC stop, restart.
  task automatic t_crystal();
    logic c_p;
    wr(OFS_CTRL1, 32'hE);
    wr(OFS_CTRL2, 32'hC);
    // The crystal run output is registered behind the configuration.
    repeat (2) @(posedge ref_clk);
    check("xtal_on", {31'h0, crystal_run}, 32'h1);
    rdchk("not_ready", OFS_CTRL1, 32'hE);
    rdchk("cpu_held", OFS_STAT, 32'h3);
    count(1'b1, 256, n);
    near("lo_clk", n, 64);
    repeat (29000) @(posedge ref_clk);
    rdchk("early", OFS_CTRL1, 32'hE);
    for (int i = 0; i < 1000 && rd[C1_RDY] !== 1'b1; i++) apb(1'b0, OFS_CTRL1, 32'h0);
    if (rd[C1_RDY] !== 1'b1) begin
      errors++;
      summarize();
    end
    // The CPU switch waits for a low old clock and a falling new clock.
    repeat (20) @(posedge ref_clk);
    rdchk("cpu_low", OFS_STAT, 32'h7);
    c_p = cpu_clock;
    n = 0;
    repeat (256) begin
      @(posedge ref_clk);
      if (cpu_clock === 1'b1 && c_p === 1'b0) n++;
      c_p = cpu_clock;
    end
    near("cpu_lo", n, 64);
    wr(OFS_PRESC, 32'h0);
    wr(OFS_CTRL1, 32'hC);
    repeat (20) @(posedge ref_clk);
    check("rc_off", {31'h0, rc_osc_run}, 32'h0);
    wr(OFS_CTRL1, 32'hE);
    wr(OFS_CTRL2, 32'h0);
    wr(OFS_PRESC, 32'h9);
    repeat (2) @(posedge ref_clk);
    check("no_lo_src", {31'h0, crystal_run}, 32'h0);
    wr(OFS_PRESC, 32'h8);
    repeat (1000) @(posedge ref_clk);
    check("p1_start", {31'h0, crystal_run}, 32'h1);
    // The terminal level bit follows the running crystal here, so it is left out.
    apb(1'b0, OFS_CTRL1, 32'h0);
    check("restart", rd & 32'hFFFFFFDF, 32'hE);
    wr(OFS_PRESC, 32'h9);
  endtask

  // Terminal read-back and external low clock.
  task automatic t_ext_low();
    ext_low_level <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rdchk("lvl1", OFS_CTRL1, 32'h2E);
    ext_low_level <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rdchk("lvl0", OFS_CTRL1, 32'hE);
    check("ext_open", {31'h0, ext_low_input_enable}, 32'h1);
    wr(OFS_CTRL2, 32'h40);
    ext_low_on <= 1'b1;
    count(1'b1, 2048, n);
    near("ext_lo", n, 2);
    apb(1'b0, OFS_CTRL1, 32'h0);
    check("forced", {31'h0, rd[C1_RDY]}, 32'h1);
    check("xtal_idle", {31'h0, crystal_run}, 32'h0);
    wr(OFS_CTRL2, 32'h0);
    ext_low_on <= 1'b0;
    wr(OFS_CTRL2, 32'h4);
    repeat (8) @(posedge ref_clk);
    check("ext_block", {31'h0, ext_low_input_enable}, 32'h0);
    check("xtal_sel", {31'h0, crystal_run}, 32'h1);
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    t_reset();
    t_rc();
    t_ext_high();
    t_halt();
    t_crystal();
    t_ext_low();
    summarize();
  end
endmodule // dual_domain_clock_manager_tb
